/* File: core/aesd_pkg.sv */
package aesd_pkg;
  localparam int KEY_W      = 256;
  localparam int BLK_W      = 128;
  localparam int CNT_W      = 4;
  localparam int NUM_RK     = 15;
  localparam int KEY_CYCLES = 14;
  localparam int PIPE_LAT   = 15;
  localparam int DRAIN_IDLE = 14;

  localparam logic [CNT_W-1:0] KEY_LAST  = CNT_W'(KEY_CYCLES - 1);
  localparam logic [CNT_W-1:0] KEY_PRE   = CNT_W'(KEY_CYCLES - 2);
  localparam logic [CNT_W-1:0] RK_FIRST  = 4'h2;
  localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(DRAIN_IDLE - 1);

  // revision code, value is arbitrary
  localparam logic [31:0] VERSION = 32'h0001_0000;

  localparam logic [7:0] GF_POLY   = 8'h1b;
  localparam logic [7:0] AFF_C     = 8'h63;
  localparam logic [7:0] INV_AFF_C = 8'h05;
  localparam logic [7:0] RCON_1    = 8'h01;
  localparam logic [7:0] MUL_E     = 8'h0e;
  localparam logic [7:0] MUL_B     = 8'h0b;
  localparam logic [7:0] MUL_D     = 8'h0d;
  localparam logic [7:0] MUL_9     = 8'h09;

  typedef struct packed {
    logic             vld;
    logic [BLK_W-1:0] data;
  } aesd_blk_t;

  typedef enum logic {KS_IDLE, KS_EXPAND} aesd_ks_state_t;
  typedef enum logic {DS_IDLE, DS_RUN} aesd_ds_state_t;

  function automatic logic [7:0] aesd_xt(input logic [7:0] b);
    return {b[6:0], 1'b0} ^ (b[7] ? GF_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] aesd_mul(input logic [7:0] a,
                                          input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = aesd_xt(x);
    end
    return p;
  endfunction

  // a^254 is the field inverse, and maps zero to zero
  function automatic logic [7:0] aesd_inv(input logic [7:0] a);
    logic [7:0] s;
    logic [7:0] r;
    s = a;
    r = 8'h01;
    for (int i = 1; i < 8; i++) begin
      s = aesd_mul(s, s);
      r = aesd_mul(r, s);
    end
    return r;
  endfunction

  function automatic logic [7:0] aesd_rotl(input logic [7:0] x,
                                           input int         n);
    return 8'((x << n) | (x >> (8 - n)));
  endfunction

  // computed s-boxes trade area for a table-free source
  function automatic logic [7:0] aesd_sbox(input logic [7:0] a);
    logic [7:0] b;
    b = aesd_inv(a);
    return b ^ aesd_rotl(b, 1) ^ aesd_rotl(b, 2) ^ aesd_rotl(b, 3)
             ^ aesd_rotl(b, 4) ^ AFF_C;
  endfunction

  function automatic logic [7:0] aesd_inv_sbox(input logic [7:0] a);
    return aesd_inv(aesd_rotl(a, 1) ^ aesd_rotl(a, 3) ^ aesd_rotl(a, 6)
                    ^ INV_AFF_C);
  endfunction
endpackage

/* File: core/aesd_core.sv */
// Behaviour
// - one clock; reset returns all control state to idle
// - constant 32-bit version output
// - accepted key load expands in 14 cycles, then key busy falls
// - key busy high from after the strobe through the last expansion cycle
// - key busy makes key loads and ciphertext strobes ignored
// - key done pulses on the final expansion cycle only
// - expanded key kept for all blocks until a new key is accepted or reset clears it
// - after key setup one ciphertext block accepted every cycle
// - decrypt busy rises the cycle after the first accepted block
// - decrypt busy makes key loads ignored
// - plaintext and its valid appear 15 cycles after acceptance
// - plaintext meaningful only while its valid is high
// - after 14 idle input cycles drain done pulses once
// - decrypt busy falls the cycle after drain done unless a block is accepted in that cycle
// - later blocks reuse the stored key without new setup
`timescale 1ns/10ps
module aesd_core
  import aesd_pkg::*;
(
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_reset,
  // key load
  input  wire logic             i_key_load_valid,
  input  wire logic [KEY_W-1:0] i_cipher_key,
  output logic                  o_key_expand_busy,
  output logic                  o_key_expand_done,
  // ciphertext in
  input  wire logic             i_ct_in_valid,
  input  wire logic [BLK_W-1:0] i_ct_in,
  output logic                  o_decrypt_busy,
  output logic                  o_drain_done,
  // plaintext out
  output logic                  o_pt_out_valid,
  output logic [BLK_W-1:0]      o_pt_out,
  // identity
  output logic [31:0]           o_version
);

  function automatic logic [31:0] sub_word(input logic [31:0] w);
    return {aesd_sbox(w[31:24]), aesd_sbox(w[23:16]),
            aesd_sbox(w[15:8]), aesd_sbox(w[7:0])};
  endfunction

  // round key idx from the two before it
  function automatic logic [BLK_W-1:0] next_rk(input logic [BLK_W-1:0] p2,
                                               input logic [BLK_W-1:0] p1,
                                               input logic [CNT_W-1:0] idx);
    logic [31:0] t;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    if (!idx[0])
      t = sub_word({p1[23:0], p1[31:24]})
          ^ {8'(RCON_1 << (idx[3:1] - 3'h1)), 24'h00_0000};
    else
      t = sub_word(p1[31:0]);
    w0 = p2[127:96] ^ t;
    w1 = p2[95:64] ^ w0;
    w2 = p2[63:32] ^ w1;
    w3 = p2[31:0] ^ w2;
    return {w0, w1, w2, w3};
  endfunction

  // byte i of the state sits at bits 127-8i; column c holds bytes 4c..4c+3
  function automatic logic [BLK_W-1:0] inv_round(input logic [BLK_W-1:0] s,
                                                 input logic [BLK_W-1:0] rk,
                                                 input logic             mix);
    logic [BLK_W-1:0] t;
    logic [BLK_W-1:0] o;
    logic [7:0]       a0;
    logic [7:0]       a1;
    logic [7:0]       a2;
    logic [7:0]       a3;
    t = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        t[127-8*(4*c+r) -: 8] =
          aesd_inv_sbox(s[127-8*(4*((c-r+4)%4)+r) -: 8]);
      end
    end
    t = t ^ rk;
    o = t;
    if (mix) begin
      for (int c = 0; c < 4; c++) begin
        a0 = t[127-32*c -: 8];
        a1 = t[119-32*c -: 8];
        a2 = t[111-32*c -: 8];
        a3 = t[103-32*c -: 8];
        o[127-32*c -: 8] = aesd_mul(a0, MUL_E) ^ aesd_mul(a1, MUL_B)
                         ^ aesd_mul(a2, MUL_D) ^ aesd_mul(a3, MUL_9);
        o[119-32*c -: 8] = aesd_mul(a0, MUL_9) ^ aesd_mul(a1, MUL_E)
                         ^ aesd_mul(a2, MUL_B) ^ aesd_mul(a3, MUL_D);
        o[111-32*c -: 8] = aesd_mul(a0, MUL_D) ^ aesd_mul(a1, MUL_9)
                         ^ aesd_mul(a2, MUL_E) ^ aesd_mul(a3, MUL_B);
        o[103-32*c -: 8] = aesd_mul(a0, MUL_B) ^ aesd_mul(a1, MUL_D)
                         ^ aesd_mul(a2, MUL_9) ^ aesd_mul(a3, MUL_E);
      end
    end
    return o;
  endfunction

  // key schedule state
  aesd_ks_state_t   ks_state_reg;
  aesd_ks_state_t   ks_state_next;
  logic [CNT_W-1:0] ks_cnt_reg;
  logic [CNT_W-1:0] ks_cnt_next;
  logic             key_busy_reg;
  logic             key_busy_next;
  logic             key_done_reg;
  logic             key_done_next;
  logic [BLK_W-1:0] rk_reg  [NUM_RK];
  logic [BLK_W-1:0] rk_next [NUM_RK];
  // decrypt control state
  aesd_ds_state_t   ds_state_reg;
  aesd_ds_state_t   ds_state_next;
  logic [CNT_W-1:0] idle_reg;
  logic [CNT_W-1:0] idle_next;
  logic             dec_busy_reg;
  logic             dec_busy_next;
  logic             drain_reg;
  logic             drain_next;
  // datapath
  aesd_blk_t        pipe_reg  [PIPE_LAT];
  aesd_blk_t        pipe_next [PIPE_LAT];
  logic             key_acc;
  logic             ct_acc;

  // a key load wins over a block in the same cycle unless decrypt busy is high
  assign key_acc = i_key_load_valid && !key_busy_reg && !dec_busy_reg;
  assign ct_acc  = i_ct_in_valid && !key_busy_reg && !key_acc;

  always_comb begin
    ks_state_next = ks_state_reg;
    ks_cnt_next   = ks_cnt_reg;
    rk_next       = rk_reg;
    key_done_next = 1'b0;
    case (ks_state_reg)
      KS_IDLE: begin
        if (key_acc) begin
          ks_state_next = KS_EXPAND;
          ks_cnt_next   = '0;
          rk_next[0]    = i_cipher_key[KEY_W-1 -: BLK_W];
          rk_next[1]    = i_cipher_key[BLK_W-1:0];
        end
      end
      KS_EXPAND: begin
        if (ks_cnt_reg == KEY_LAST) begin
          ks_state_next = KS_IDLE;
        end else begin
          ks_cnt_next = ks_cnt_reg + 4'h1;
          // steps 0..12 fill keys 2..14; the last step only signals done
          rk_next[ks_cnt_reg + RK_FIRST] =
            next_rk(rk_reg[ks_cnt_reg], rk_reg[ks_cnt_reg + 4'h1],
                    ks_cnt_reg + RK_FIRST);
        end
        key_done_next = (ks_cnt_reg == KEY_PRE);
      end
      default: ks_state_next = KS_IDLE;
    endcase
    key_busy_next = (ks_state_next == KS_EXPAND);
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ks_state_reg <= KS_IDLE;
      ks_cnt_reg   <= '0;
      key_busy_reg <= 1'b0;
      key_done_reg <= 1'b0;
      for (int i = 0; i < NUM_RK; i++) rk_reg[i] <= '0;
    end else begin
      ks_state_reg <= ks_state_next;
      ks_cnt_reg   <= ks_cnt_next;
      key_busy_reg <= key_busy_next;
      key_done_reg <= key_done_next;
      rk_reg       <= rk_next;
    end
  end

  always_comb begin
    ds_state_next = ds_state_reg;
    idle_next     = (ct_acc || !dec_busy_reg) ? '0 : idle_reg + 4'h1;
    drain_next    = 1'b0;
    case (ds_state_reg)
      DS_IDLE: if (ct_acc) ds_state_next = DS_RUN;
      DS_RUN: begin
        drain_next = !ct_acc && (idle_reg == IDLE_LAST);
        if (drain_reg && !ct_acc) ds_state_next = DS_IDLE;
      end
      default: ds_state_next = DS_IDLE;
    endcase
    dec_busy_next = (ds_state_next == DS_RUN);
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ds_state_reg <= DS_IDLE;
      idle_reg     <= '0;
      dec_busy_reg <= 1'b0;
      drain_reg    <= 1'b0;
    end else begin
      ds_state_reg <= ds_state_next;
      idle_reg     <= idle_next;
      dec_busy_reg <= dec_busy_next;
      drain_reg    <= drain_next;
    end
  end

  // every stage computes each cycle; valid bits mark real blocks
  always_comb begin
    pipe_next[0].vld  = ct_acc;
    pipe_next[0].data = i_ct_in ^ rk_reg[NUM_RK-1];
    for (int k = 1; k < PIPE_LAT; k++) begin
      pipe_next[k].vld  = pipe_reg[k-1].vld;
      pipe_next[k].data = inv_round(pipe_reg[k-1].data, rk_reg[NUM_RK-1-k],
                                    k != PIPE_LAT - 1);
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < PIPE_LAT; k++) pipe_reg[k] <= '0;
      o_version <= VERSION;
    end else begin
      pipe_reg  <= pipe_next;
      o_version <= VERSION;
    end
  end

  assign o_key_expand_busy = key_busy_reg;
  assign o_key_expand_done = key_done_reg;
  assign o_decrypt_busy    = dec_busy_reg;
  assign o_drain_done      = drain_reg;
  assign o_pt_out_valid    = pipe_reg[PIPE_LAT-1].vld;
  assign o_pt_out          = pipe_reg[PIPE_LAT-1].data;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  sequence s_busy14;
    o_key_expand_busy[*8] ##1 o_key_expand_busy[*6] ##1 !o_key_expand_busy;
  endsequence
  sequence s_quiet14;
    ct_acc ##1 !i_ct_in_valid[*8] ##1 !i_ct_in_valid[*6];
  endsequence

  a_key_busy_len: assert property (key_acc |=> s_busy14)
    else $error("key busy not 14 cycles");
  a_key_done_end: assert property (key_acc |=> ##13 o_key_expand_done
                                    ##1 !o_key_expand_done)
    else $error("key done misplaced");
  a_key_excl: assert property (o_key_expand_busy |-> !o_decrypt_busy)
    else $error("block accepted during key setup");
  a_key_hold: assert property (o_decrypt_busy && i_key_load_valid
                               |=> !o_key_expand_busy)
    else $error("key load taken while decrypting");
  a_busy_rise: assert property (ct_acc && !o_decrypt_busy
                                |=> o_decrypt_busy)
    else $error("decrypt busy did not rise");
  a_pt_latency: assert property (ct_acc |-> ##15 o_pt_out_valid)
    else $error("plaintext not 15 cycles after block");
  a_pt_source: assert property (o_pt_out_valid |-> $past(ct_acc, 15))
    else $error("plaintext without accepted block");
  a_drain_time: assert property (s_quiet14 |=> o_drain_done)
    else $error("drain done missing");
  a_drain_drop: assert property (o_drain_done && !ct_acc
                                 |=> !o_drain_done && !o_decrypt_busy)
    else $error("busy not cleared after drain");
  a_version_val: assert property (o_version == VERSION)
    else $error("version changed");

endmodule

/* File: testbench/aesd_user_model.sv */
`timescale 1ns/10ps
module aesd_user_model
  import aesd_pkg::*;
(
  // clock
  input  wire logic        i_core_clk,
  // key and ciphertext towards the core
  output logic             o_key_load_valid,
  output logic [KEY_W-1:0] o_cipher_key,
  output logic             o_ct_in_valid,
  output logic [BLK_W-1:0] o_ct_in
);
  initial begin
    o_key_load_valid = 1'b0;
    o_cipher_key     = '0;
    o_ct_in_valid    = 1'b0;
    o_ct_in          = '0;
  end

  // one cycle of traffic; idle buses flip so stale data never matches
  task automatic step(input logic             kv,
                      input logic [KEY_W-1:0] k,
                      input logic             cv,
                      input logic [BLK_W-1:0] c);
    @(posedge i_core_clk);
    o_key_load_valid <= kv;
    o_cipher_key     <= kv ? k : ~o_cipher_key;
    o_ct_in_valid    <= cv;
    o_ct_in          <= cv ? c : ~o_ct_in;
  endtask
endmodule

/* File: testbench/aesd_core_test.sv */
`timescale 1ns/10ps
module aesd_core_test
  import aesd_pkg::*;
;
  localparam logic [KEY_W-1:0] KEY1 =
    256'h000102030405060708090a0b0c0d0e0f101112131415161718191a1b1c1d1e1f;
  localparam logic [BLK_W-1:0] CT1 = 128'h8ea2b7ca516745bfeafc49904b496089;
  localparam logic [BLK_W-1:0] PT1 = 128'h00112233445566778899aabbccddeeff;
  localparam logic [BLK_W-1:0] CT0 = 128'hdc95c078a2408989ad48a21492842087;

  logic                            i_core_clk;
  logic                            i_reset;
  logic                            kv;
  logic [KEY_W-1:0]                key;
  logic                            cv;
  logic [BLK_W-1:0]                ct;
  logic                            kbusy;
  logic                            kdone;
  logic                            dbusy;
  logic                            drain;
  logic                            ptv;
  logic [BLK_W-1:0]                pt;
  logic [31:0]                     ver;
  logic [PIPE_LAT-1:0]             hist;
  logic [PIPE_LAT-1:0]             known;
  logic [PIPE_LAT-1:0][BLK_W-1:0]  pexp;
  logic [4:0]                      kcnt;
  logic [1:0]                      kid;
  logic                            ka;
  logic                            ca;
  logic [BLK_W:0]                  r;
  int                              n_fail;
  int                              comparisons;
  int                              cycles;

  aesd_user_model user_u (
    .i_core_clk       (i_core_clk),
    .o_key_load_valid (kv),
    .o_cipher_key     (key),
    .o_ct_in_valid    (cv),
    .o_ct_in          (ct)
  );

  aesd_core dut_u (
    .i_core_clk        (i_core_clk),
    .i_reset           (i_reset),
    .i_key_load_valid  (kv),
    .i_cipher_key      (key),
    .o_key_expand_busy (kbusy),
    .o_key_expand_done (kdone),
    .i_ct_in_valid     (cv),
    .i_ct_in           (ct),
    .o_decrypt_busy    (dbusy),
    .o_drain_done      (drain),
    .o_pt_out_valid    (ptv),
    .o_pt_out          (pt),
    .o_version         (ver)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // known answers only; other blocks are checked for timing alone
  function automatic logic [BLK_W:0] ref_pt(input logic [1:0]       id,
                                            input logic [BLK_W-1:0] c);
    if (id == 2'd0 && c === CT0) return {1'b1, 128'h0};
    if (id == 2'd1 && c === CT1) return {1'b1, PT1};
    return '0;
  endfunction

  function automatic logic [BLK_W-1:0] rnd();
    return {$urandom, $urandom, $urandom, $urandom};
  endfunction

  // reference of the port timing
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      hist  <= '0;
      known <= '0;
      kcnt  <= '0;
      // reset leaves an all-zero schedule, not the expanded zero key
      kid   <= 2'd2;
    end else begin
      ka = kv && kcnt == 0 && hist == '0;
      ca = cv && kcnt == 0 && !ka;
      r  = ref_pt(kid, ct);
      hist  <= {hist[PIPE_LAT-2:0], ca};
      known <= {known[PIPE_LAT-2:0], ca & r[BLK_W]};
      pexp  <= {pexp[PIPE_LAT-2:0], r[BLK_W-1:0]};
      if (ka) begin
        kcnt <= 5'(KEY_CYCLES);
        kid  <= (key === KEY1) ? 2'd1 : (key === '0) ? 2'd0 : 2'd2;
      end else if (kcnt != 0) begin
        kcnt <= kcnt - 5'd1;
      end
    end
  end

  task automatic check(input logic [BLK_W-1:0] got,
                       input logic [BLK_W-1:0] exp,
                       input string            what);
    // the time-zero clock edge comes before any reset edge
    if (cycles == 0) return;
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  always @(negedge i_core_clk) begin
    check(ver, VERSION, "version");
    check(kbusy, kcnt != 0, "key busy");
    check(kdone, kcnt == 1, "key done");
    check(dbusy, hist != '0, "decrypt busy");
    check(drain, hist[14] && hist[13:0] == '0, "drain done");
    check(ptv, hist[14], "plaintext valid");
    if (known[14]) check(pt, pexp[14], "plaintext");
  end

  task automatic report_and_stop();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // a ceiling far above the planned few hundred cycles
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic idle(input int n);
    repeat (n) user_u.step(1'b0, '0, 1'b0, '0);
  endtask

  initial begin
    i_reset = 1'b1;
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    void'($urandom(71331));
    repeat (20) @(posedge i_core_clk);
    i_reset <= 1'b0;
    user_u.step(1'b0, '0, 1'b1, CT0);
    idle(18);
    user_u.step(1'b1, KEY1, 1'b0, '0);
    // strobes inside the busy window, then the first free cycles
    for (int i = 0; i < 16; i++)
      user_u.step(i[0], '0, 1'b1, CT1);
    for (int i = 0; i < 60; i++)
      user_u.step($urandom % 8 == 0, '0, $urandom % 2 == 0,
                  ($urandom % 4 == 0) ? CT1 : rnd());
    idle(16);
    for (int g = 13; g <= 15; g++) begin
      user_u.step(1'b0, '0, 1'b1, CT1);
      idle(g);
    end
    idle(4);
    user_u.step(1'b1, '0, 1'b1, CT1);
    idle(16);
    user_u.step(1'b0, '0, 1'b1, CT0);
    idle(16);
    user_u.step(1'b1, {rnd(), rnd()}, 1'b0, '0);
    idle(14);
    for (int i = 0; i < 20; i++)
      user_u.step(1'b0, '0, $urandom % 2 == 0, rnd());
    i_reset <= 1'b1;
    idle(3);
    i_reset <= 1'b0;
    user_u.step(1'b0, '0, 1'b1, CT0);
    idle(20);
    report_and_stop();
  end
endmodule
